/* src/interrupt_priority_and_sources.sv */
// Interrupt priority, pin, timer and port-change sources with context save
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defines.svh"
module interrupt_priority_and_sources
  import irq_prio_pkg::*;
#(
  parameter int STACK_DEPTH = 31,
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins from outside
  input wire logic [3:0] ext_pins,
  input wire logic [3:0] port_b_pins,
  // Peripheral requests: eeprom, cmp3, cmp2, cmp1
  input wire logic [3:0] periph_req,
  input wire logic cfg_mismatch_rst,
  // Core handshake
  input wire logic sleep_req,
  input wire logic irq_entry,
  input wire logic irq_return,
  input wire core_ctx_t core_ctx,
  // Requests and context to the core
  output logic irq_high,
  output logic irq_low,
  output logic wake,
  output logic vector_take,
  output logic pullup_off,
  output logic [20:0] ret_pc,
  output core_ctx_t fast_ctx
);
  localparam int PTR_W = $clog2(STACK_DEPTH + 1);

  generate
    if (STACK_DEPTH < 2 || ADDR_W < 8) begin : g_bad
      $error("unsupported stack depth or address width");
    end
  endgenerate

  logic [7:0] irq_control_one;
  logic [7:0] irq_control_two;
  logic [7:0] irq_control_three;
  logic [7:0] peripheral_priority_six;
  logic [7:0] reset_cause_control;
  logic [1:0] timer_zero_ctl;
  logic [15:0] timer_zero_count_pair;
  logic [3:0] ext_meta, ext_sync, ext_prev;
  logic [3:0] pb_meta, pb_sync, pb_prev;
  logic [3:0] ext_edge;
  logic [3:0] ext_edge_select;
  logic [3:0] ext_pin_flag;
  logic [3:0] ext_pin_enable;
  logic [3:0] ext_armed;
  logic [20:0] stack_mem [STACK_DEPTH];
  logic [PTR_W-1:0] stack_ptr;
  pm_state_t pm_state;
  logic wr_en, rd_setup;
  logic [7:0] wbyte;
  logic timer_roll, port_change;
  logic hi_any, lo_any, all_any;
  logic mapped, addr_hi_ok;
  logic [7:0] rd_byte;

  // Two stages before any logic sees the pins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_meta <= 4'h0;
      ext_sync <= 4'h0;
      ext_prev <= 4'h0;
      pb_meta <= 4'h0;
      pb_sync <= 4'h0;
      pb_prev <= 4'h0;
    end else if (ce) begin
      ext_meta <= ext_pins;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
      pb_meta <= port_b_pins;
      pb_sync <= pb_meta;
      pb_prev <= pb_sync;
    end
  end

  // Write takes effect only in the access phase with pready high
  // Upper address bits must be zero or the access is refused
  assign addr_hi_ok = (paddr >> 8) == '0;
  assign wr_en = ce & psel & penable & pwrite & pready & addr_hi_ok;
  assign rd_setup = ce & psel & ~penable & ~pready;
  assign wbyte = pwdata[7:0];

  assign ext_edge_select = {irq_control_two[`C2_EDGE3],
    irq_control_two[`C2_EDGE2], irq_control_two[`C2_EDGE1],
    irq_control_two[`C2_EDGE0]};
  assign ext_pin_flag = {irq_control_three[`C3_EXT3_FLAG],
    irq_control_three[`C3_EXT2_FLAG], irq_control_three[`C3_EXT1_FLAG],
    irq_control_one[`C1_EXT0_FLAG]};
  assign ext_pin_enable = {irq_control_three[`C3_EXT3_EN],
    irq_control_three[`C3_EXT2_EN], irq_control_three[`C3_EXT1_EN],
    irq_control_one[`C1_EXT0_EN]};

  // Polarity chosen per pin by its select bit
  assign ext_edge = (ext_edge_select & ext_sync & ~ext_prev) |
    (~ext_edge_select & ~ext_sync & ext_prev);

  assign port_change = |(pb_sync ^ pb_prev);

  // Eight-bit mode watches only the low byte
  assign timer_roll = timer_zero_ctl[`TC_RUN] & (timer_zero_ctl[`TC_WIDE] ?
    (timer_zero_count_pair == `WORD_ALL_ONES) :
    (timer_zero_count_pair[7:0] == `BYTE_ALL_ONES));

  // Control one: hardware set wins over a software clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_control_one <= `RST_CTL_ONE;
    end else if (ce) begin
      if (wr_en && paddr[7:0] == `OFS_CTL_ONE) begin
        irq_control_one <= wbyte;
      end
      if (timer_roll) begin
        irq_control_one[`C1_TMR_FLAG] <= 1'b1;
      end
      if (ext_edge[0]) begin
        irq_control_one[`C1_EXT0_FLAG] <= 1'b1;
      end
      if (port_change) begin
        irq_control_one[`C1_PCH_FLAG] <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_control_two <= `RST_CTL_TWO;
    end else if (ce && wr_en && paddr[7:0] == `OFS_CTL_TWO) begin
      irq_control_two <= wbyte;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_control_three <= `RST_CTL_THREE;
    end else if (ce) begin
      if (wr_en && paddr[7:0] == `OFS_CTL_THREE) begin
        irq_control_three <= wbyte;
      end
      if (ext_edge[1]) begin
        irq_control_three[`C3_EXT1_FLAG] <= 1'b1;
      end
      if (ext_edge[2]) begin
        irq_control_three[`C3_EXT2_FLAG] <= 1'b1;
      end
      if (ext_edge[3]) begin
        irq_control_three[`C3_EXT3_FLAG] <= 1'b1;
      end
    end
  end

  // Unimplemented bits never store
  always_ff @(posedge core_clk) begin
    if (rst) begin
      peripheral_priority_six <= `RST_PRIO_SIX;
    end else if (ce && wr_en && paddr[7:0] == `OFS_PRIO_SIX) begin
      peripheral_priority_six <= wbyte & `P6_MASK;
    end
  end

  // Mismatch reset beats a software set in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reset_cause_control <= `RST_RCAUSE;
    end else if (ce) begin
      if (wr_en && paddr[7:0] == `OFS_RCAUSE) begin
        reset_cause_control <= (wbyte & ~`RC_RO_MASK) |
          (reset_cause_control & `RC_RO_MASK);
      end
      if (cfg_mismatch_rst) begin
        reset_cause_control[`RC_CFG_MISMATCH] <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_zero_ctl <= 2'h0;
    end else if (ce && wr_en && paddr[7:0] == `OFS_TMR_CTL) begin
      timer_zero_ctl <= wbyte[1:0];
    end
  end

  // Counts one per enabled clock; the high byte stands still in 8-bit mode
  always_ff @(posedge core_clk) begin
    if (rst) begin
      timer_zero_count_pair <= 16'h0000;
    end else if (ce) begin
      if (wr_en && paddr[7:0] == `OFS_TMR_CNT) begin
        timer_zero_count_pair <= pwdata[15:0];
      end else if (timer_zero_ctl[`TC_RUN]) begin
        if (timer_zero_ctl[`TC_WIDE]) begin
          timer_zero_count_pair <= timer_zero_count_pair + 16'h0001;
        end else begin
          timer_zero_count_pair[7:0] <= timer_zero_count_pair[7:0] + 8'h01;
        end
      end
    end
  end

  // Request grouping per priority level
  always_comb begin
    logic [3:0] p_act;
    logic [3:0] e_act;
    logic t_act, c_act;
    logic [3:0] e_prio;
    e_prio = {irq_control_two[`C2_EXT3_PRIO],
      irq_control_three[`C3_EXT2_PRIO],
      irq_control_three[`C3_EXT1_PRIO], 1'b1};
    e_act = ext_pin_flag & ext_pin_enable;
    t_act = irq_control_one[`C1_TMR_FLAG] &
      irq_control_one[`C1_TMR_EN];
    c_act = irq_control_one[`C1_PCH_FLAG] &
      irq_control_one[`C1_PCH_EN];
    p_act = periph_req;
    hi_any = |(e_act & e_prio) |
      (t_act & irq_control_two[`C2_TMR_PRIO]) |
      (c_act & irq_control_two[`C2_PCH_PRIO]) |
      (p_act[3] & peripheral_priority_six[`P6_EEPROM]) |
      (|(p_act[2:0] & peripheral_priority_six[2:0]));
    lo_any = |(e_act & ~e_prio) |
      (t_act & ~irq_control_two[`C2_TMR_PRIO]) |
      (c_act & ~irq_control_two[`C2_PCH_PRIO]) |
      (p_act[3] & ~peripheral_priority_six[`P6_EEPROM]) |
      (|(p_act[2:0] & ~peripheral_priority_six[2:0]));
    all_any = (|e_act) | t_act | c_act |
      (irq_control_one[`C1_PEIE] & (|p_act));
  end

  // In compatibility mode every source goes out on the high line
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_high <= 1'b0;
      irq_low <= 1'b0;
    end else if (ce) begin
      if (reset_cause_control[`RC_PRIO_ON]) begin
        irq_high <= irq_control_one[`C1_GIE] & hi_any;
        irq_low <= irq_control_one[`C1_PEIE] & lo_any;
      end else begin
        irq_high <= irq_control_one[`C1_GIE] & all_any;
        irq_low <= 1'b0;
      end
    end
  end

  // Enables are captured at sleep entry so a later set cannot wake
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pm_state <= PM_RUN;
      ext_armed <= 4'h0;
      wake <= 1'b0;
      vector_take <= 1'b0;
    end else if (ce) begin
      wake <= 1'b0;
      vector_take <= 1'b0;
      unique case (pm_state)
        PM_RUN: begin
          if (sleep_req) begin
            pm_state <= PM_SLEEP;
            ext_armed <= ext_pin_enable;
          end
        end
        PM_SLEEP: begin
          if (|(ext_armed & ext_pin_flag)) begin
            pm_state <= PM_RUN;
            wake <= 1'b1;
            vector_take <= irq_control_one[`C1_GIE];
          end
        end
      endcase
    end
  end

  // Return stack; a push when full overwrites the top entry
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stack_ptr <= '0;
      ret_pc <= 21'h000000;
    end else if (ce) begin
      if (irq_entry) begin
        if (stack_ptr == PTR_W'(STACK_DEPTH)) begin
          stack_mem[STACK_DEPTH-1] <= core_ctx.pc;
        end else begin
          stack_mem[stack_ptr] <= core_ctx.pc;
          stack_ptr <= stack_ptr + PTR_W'(1);
        end
        ret_pc <= core_ctx.pc;
      end else if (irq_return && stack_ptr != '0) begin
        stack_ptr <= stack_ptr - PTR_W'(1);
        ret_pc <= (stack_ptr > PTR_W'(1)) ?
          stack_mem[stack_ptr - PTR_W'(2)] : 21'h000000;
      end
    end
  end

  // Shadow holds one level only; nested entries overwrite it
  always_ff @(posedge core_clk) begin
    if (rst) begin
      fast_ctx <= '0;
    end else if (ce && irq_entry) begin
      fast_ctx <= core_ctx;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pullup_off <= 1'b1;
    end else if (ce) begin
      pullup_off <= irq_control_two[`C2_PULLUP_OFF];
    end
  end

  // Read mux
  always_comb begin
    mapped = 1'b1;
    rd_byte = 8'h00;
    unique case (paddr[7:0])
      `OFS_CTL_ONE: rd_byte = irq_control_one;
      `OFS_CTL_TWO: rd_byte = irq_control_two;
      `OFS_CTL_THREE: rd_byte = irq_control_three;
      `OFS_PRIO_SIX: rd_byte = peripheral_priority_six & `P6_MASK;
      `OFS_RCAUSE: rd_byte = reset_cause_control;
      `OFS_TMR_CTL: rd_byte = {6'h00, timer_zero_ctl};
      `OFS_TMR_CNT: rd_byte = timer_zero_count_pair[7:0];
      `OFS_CTX_STAT: rd_byte = {pm_state == PM_SLEEP, 2'h0,
        5'(stack_ptr)};
      default: mapped = 1'b0;
    endcase
  end

  // No wait state: data and pready register in the setup cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= rd_setup;
      pslverr <= rd_setup & (~mapped | ~addr_hi_ok);
      if (rd_setup) begin
        if (!addr_hi_ok) begin
          prdata <= 32'h00000000;
        end else if (paddr[7:0] == `OFS_TMR_CNT) begin
          prdata <= {16'h0000, timer_zero_count_pair};
        end else begin
          prdata <= {24'h000000, rd_byte};
        end
      end
    end
  end
endmodule
`default_nettype wire

/* src/irq_prio_defines.svh */
// Register map, field positions and reset values of the interrupt block
`ifndef IRQ_PRIO_DEFINES_SVH
`define IRQ_PRIO_DEFINES_SVH
`define OFS_CTL_ONE 8'h00
`define OFS_CTL_TWO 8'h04
`define OFS_CTL_THREE 8'h08
`define OFS_PRIO_SIX 8'h0C
`define OFS_RCAUSE 8'h10
`define OFS_TMR_CTL 8'h14
`define OFS_TMR_CNT 8'h18
`define OFS_CTX_STAT 8'h1C
// irq_control_one
`define C1_GIE 7
`define C1_PEIE 6
`define C1_TMR_EN 5
`define C1_EXT0_EN 4
`define C1_PCH_EN 3
`define C1_TMR_FLAG 2
`define C1_EXT0_FLAG 1
`define C1_PCH_FLAG 0
// irq_control_two
`define C2_PULLUP_OFF 7
`define C2_EDGE0 6
`define C2_EDGE1 5
`define C2_EDGE2 4
`define C2_EDGE3 3
`define C2_TMR_PRIO 2
`define C2_EXT3_PRIO 1
`define C2_PCH_PRIO 0
// irq_control_three
`define C3_EXT2_PRIO 7
`define C3_EXT1_PRIO 6
`define C3_EXT3_EN 5
`define C3_EXT2_EN 4
`define C3_EXT1_EN 3
`define C3_EXT3_FLAG 2
`define C3_EXT2_FLAG 1
`define C3_EXT1_FLAG 0
// peripheral_priority_six
`define P6_EEPROM 4
`define P6_CMP3 2
`define P6_CMP2 1
`define P6_CMP1 0
`define P6_MASK 8'h17
// reset_cause_control
`define RC_PRIO_ON 7
`define RC_CFG_MISMATCH 5
`define RC_RO_MASK 8'h0C
// timer control
`define TC_RUN 0
`define TC_WIDE 1
`define RST_CTL_ONE 8'h00
`define RST_CTL_TWO 8'hFF
`define RST_CTL_THREE 8'hC0
`define RST_PRIO_SIX 8'h17
`define RST_RCAUSE 8'h7C
`define BYTE_ALL_ONES 8'hFF
`define WORD_ALL_ONES 16'hFFFF
`endif

/* src/irq_prio_pkg.sv */
// Types shared by the interrupt priority block
package irq_prio_pkg;
  typedef struct packed {
    logic [20:0] pc;
    logic [7:0] working_register;
    logic [7:0] status;
    logic [7:0] bank_select_register;
  } core_ctx_t;
  typedef enum logic {PM_RUN, PM_SLEEP} pm_state_t;
endpackage

/* dv/irq_prio_sva.sv */
// Port-level assertions for the interrupt priority block
`timescale 1ns/1ps
`default_nettype none
module irq_prio_sva
  import irq_prio_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  // Register bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Core side
  input wire logic irq_entry,
  input wire logic irq_return,
  input wire core_ctx_t core_ctx,
  input wire logic wake,
  input wire logic vector_take,
  input wire logic irq_high,
  input wire logic pullup_off,
  input wire logic [20:0] ret_pc,
  input wire core_ctx_t fast_ctx
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    ce && psel && !penable;
  endsequence
  sequence s_entry;
    ce && irq_entry && !irq_return;
  endsequence
  a_setup_answer: assert property (s_setup |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_ret_push: assert property (
    s_entry |=> ret_pc == $past(core_ctx.pc))
    else $error("return address not pushed");
  a_shadow_copy: assert property (
    s_entry |=> fast_ctx == $past(core_ctx))
    else $error("shadow copy wrong");
  a_shadow_hold: assert property (
    !irq_entry |=> $stable(fast_ctx))
    else $error("shadow changed without entry");
  a_vector_wake: assert property (vector_take |-> wake)
    else $error("vector taken without wake");
  a_wake_pulse: assert property (wake |=> !wake)
    else $error("wake longer than one cycle");
  a_reset_state: assert property (
    $fell(rst) |-> pullup_off && !irq_high && !pready)
    else $error("outputs not at reset state");
endmodule
bind interrupt_priority_and_sources irq_prio_sva i_irq_prio_sva (
  .core_clk, .rst, .ce, .psel, .penable, .pready, .pslverr, .irq_entry,
  .irq_return, .core_ctx, .wake, .vector_take, .irq_high, .pullup_off,
  .ret_pc, .fast_ctx);
`default_nettype wire

/* dv/core_pin_model.sv */
// Model of the core and the external pins facing the block
`timescale 1ns/1ps
`default_nettype none
module core_pin_model
  import irq_prio_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // Pins
  output logic [3:0] ext_pins,
  output logic [3:0] port_b_pins,
  // Core
  output logic sleep_req,
  output logic irq_entry,
  output logic irq_return,
  output core_ctx_t core_ctx
);
  core_ctx_t saved;
  initial begin
    ext_pins = 4'h0;
    port_b_pins = 4'h0;
    sleep_req = 1'b0;
    irq_entry = 1'b0;
    irq_return = 1'b0;
    core_ctx = '0;
  end
  task automatic pins(input logic [3:0] e, input logic [3:0] b);
    @(posedge core_clk);
    ext_pins <= e;
    port_b_pins <= b;
  endtask
  task automatic set_sleep(input logic s);
    @(posedge core_clk);
    sleep_req <= s;
  endtask
  // Context is only valid with the entry pulse; scrambled afterwards
  task automatic enter(input core_ctx_t c);
    @(posedge core_clk);
    core_ctx <= c;
    irq_entry <= 1'b1;
    saved <= c;
    @(posedge core_clk);
    irq_entry <= 1'b0;
    core_ctx <= ~c;
  endtask
  // Service software puts back the context it saved on entry
  task automatic leave;
    @(posedge core_clk);
    irq_return <= 1'b1;
    @(posedge core_clk);
    irq_return <= 1'b0;
    core_ctx <= saved;
  endtask
endmodule
`default_nettype wire

/* dv/tb_interrupt_priority_and_sources.sv */
// Self-checking bench for the interrupt priority block
`timescale 1ns/1ps
`default_nettype none
`include "irq_prio_defines.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module tb_interrupt_priority_and_sources;
  import irq_prio_pkg::*;
  logic core_clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic cfg_mismatch_rst, sleep_req, irq_entry, irq_return;
  logic irq_high, irq_low, wake, vector_take, pullup_off;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] ext_pins, port_b_pins, periph_req;
  logic [20:0] ret_pc;
  core_ctx_t core_ctx, fast_ctx, ca, cb;
  int num_errors, cmp_count;
  interrupt_priority_and_sources i_interrupt_priority_and_sources (
    .core_clk, .rst, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .ext_pins, .port_b_pins, .periph_req,
    .cfg_mismatch_rst, .sleep_req, .irq_entry, .irq_return, .core_ctx,
    .irq_high, .irq_low, .wake, .vector_take, .pullup_off, .ret_pc,
    .fast_ctx);
  core_pin_model i_core_pin_model (.core_clk, .ext_pins, .port_b_pins,
    .sleep_req, .irq_entry, .irq_return, .core_ctx);
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic complete_run;
    if (num_errors == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    `CHK(pready, 1'b1)
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(q[7:0], e)
  endtask
  task automatic irqc(input logic h, input logic l);
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `CHK(irq_high, h)
    `CHK(irq_low, l)
  endtask
  task automatic t_regs;
    rdc(`OFS_PRIO_SIX, 8'h17);
    rdc(`OFS_RCAUSE, 8'h7C);
    wr(`OFS_PRIO_SIX, 8'hFF);
    rdc(`OFS_PRIO_SIX, 8'h17);
    wr(`OFS_PRIO_SIX, 8'h00);
    rdc(`OFS_PRIO_SIX, 8'h00);
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
  endtask
  task automatic t_cfg;
    @(posedge core_clk);
    cfg_mismatch_rst <= 1'b1;
    @(posedge core_clk);
    cfg_mismatch_rst <= 1'b0;
    rdc(`OFS_RCAUSE, 8'h5C);
    wr(`OFS_RCAUSE, 8'hFC);
    rdc(`OFS_RCAUSE, 8'hFC);
  endtask
  // Every pin with both edge selects; only the toggled pin flags
  task automatic t_ext;
    for (int p = 0; p < 2; p++) begin
      for (int k = 0; k < 4; k++) begin
        wr(`OFS_CTL_TWO, p[0] ? 8'hFF : 8'h87);
        i_core_pin_model.pins({4{~p[0]}}, 4'h0);
        repeat (4) @(posedge core_clk);
        wr(`OFS_CTL_ONE, 8'h00);
        wr(`OFS_CTL_THREE, 8'hC0);
        i_core_pin_model.pins({4{~p[0]}} ^ (4'h1 << k), 4'h0);
        repeat (4) @(posedge core_clk);
        rdc(`OFS_CTL_ONE, k == 0 ? 8'h02 : 8'h00);
        rdc(`OFS_CTL_THREE, k == 0 ? 8'hC0 : 8'hC0 | (8'h1 << (k - 1)));
      end
    end
  endtask
  task automatic t_irq;
    wr(`OFS_CTL_TWO, 8'hF8);
    wr(`OFS_CTL_THREE, 8'h00);
    i_core_pin_model.pins(4'h1, 4'h0);
    repeat (4) @(posedge core_clk);
    wr(`OFS_CTL_ONE, 8'hD2);
    irqc(1'b1, 1'b0);
    wr(`OFS_CTL_ONE, 8'hC2);
    irqc(1'b0, 1'b0);
    wr(`OFS_CTL_ONE, 8'hC0);
    wr(`OFS_CTL_ONE, 8'hD0);
    irqc(1'b0, 1'b0);
    i_core_pin_model.pins(4'h3, 4'h0);
    repeat (4) @(posedge core_clk);
    wr(`OFS_CTL_THREE, 8'h09);
    irqc(1'b0, 1'b1);
    wr(`OFS_CTL_THREE, 8'h49);
    irqc(1'b1, 1'b0);
    wr(`OFS_CTL_THREE, 8'h00);
  endtask
  task automatic tmr_run(input logic [31:0] c, input logic [7:0] m,
                         input logic [7:0] e);
    wr(`OFS_CTL_ONE, 8'h00);
    apb(1'b1, `OFS_TMR_CNT, c);
    wr(`OFS_TMR_CTL, m);
    repeat (6) @(posedge core_clk);
    wr(`OFS_TMR_CTL, 8'h00);
    rdc(`OFS_CTL_ONE, e);
  endtask
  task automatic t_timer;
    tmr_run(32'hFE, 8'h01, 8'h04);
    wr(`OFS_CTL_ONE, 8'hE4);
    wr(`OFS_CTL_TWO, 8'hFC);
    irqc(1'b1, 1'b0);
    wr(`OFS_CTL_TWO, 8'hF8);
    irqc(1'b0, 1'b1);
    wr(`OFS_RCAUSE, 8'h7C);
    irqc(1'b1, 1'b0);
    wr(`OFS_RCAUSE, 8'hFC);
    tmr_run(32'hFE, 8'h03, 8'h00);
    tmr_run(32'hFFFE, 8'h03, 8'h04);
  endtask
  task automatic t_port;
    wr(`OFS_CTL_ONE, 8'h00);
    i_core_pin_model.pins(4'h3, 4'h4);
    repeat (4) @(posedge core_clk);
    rdc(`OFS_CTL_ONE, 8'h01);
    wr(`OFS_CTL_ONE, 8'h89);
    wr(`OFS_CTL_TWO, 8'hF9);
    irqc(1'b1, 1'b0);
  endtask
  // Eeprom and comparator three requests on each priority level
  task automatic t_periph;
    wr(`OFS_CTL_ONE, 8'hC0);
    wr(`OFS_PRIO_SIX, 8'h00);
    @(posedge core_clk);
    periph_req <= 4'h8;
    irqc(1'b0, 1'b1);
    wr(`OFS_PRIO_SIX, 8'h10);
    irqc(1'b1, 1'b0);
    @(posedge core_clk);
    periph_req <= 4'h4;
    irqc(1'b0, 1'b1);
    wr(`OFS_PRIO_SIX, 8'h04);
    irqc(1'b1, 1'b0);
    @(posedge core_clk);
    periph_req <= 4'h0;
  endtask
  task automatic t_sleep;
    i_core_pin_model.pins(4'h0, 4'h4);
    repeat (4) @(posedge core_clk);
    wr(`OFS_CTL_ONE, 8'h90);
    // One-cycle request; the core then stays asleep until woken
    i_core_pin_model.set_sleep(1'b1);
    i_core_pin_model.set_sleep(1'b0);
    repeat (3) @(posedge core_clk);
    i_core_pin_model.pins(4'h1, 4'h4);
    for (int i = 0; i < 20 && wake !== 1'b1; i++) @(negedge core_clk);
    `CHK(wake, 1'b1)
    `CHK(vector_take, 1'b1)
    wr(`OFS_CTL_ONE, 8'h00);
  endtask
  task automatic t_ctx;
    ca = {21'h1ABCD, 24'hA1B2C3};
    cb = {21'h0F00F, 24'h5A6B7C};
    i_core_pin_model.enter(ca);
    @(negedge core_clk);
    `CHK(fast_ctx, ca)
    `CHK(ret_pc, ca.pc)
    i_core_pin_model.enter(cb);
    @(negedge core_clk);
    `CHK(ret_pc, cb.pc)
    i_core_pin_model.leave();
    @(negedge core_clk);
    `CHK(ret_pc, ca.pc)
  endtask
  initial begin
    #500000;
    num_errors++;
    $display("ERROR %0t: timeout", $time);
    complete_run();
  end
  initial begin
    num_errors = 0;
    cmp_count = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cfg_mismatch_rst = 1'b0;
    periph_req = 4'h0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_regs();
    t_cfg();
    t_ext();
    t_irq();
    t_timer();
    t_port();
    t_periph();
    t_sleep();
    t_ctx();
    complete_run();
  end
endmodule
`default_nettype wire
